// File: verilog/mmb_defines.svh
/*
 * Constants of the minimum-mode bus control block: status code field
 * positions, reset levels of the bus control outputs and timing counts.
 * Assumes inclusion by bare name from files of the verilog/ folder.
 */
`ifndef MMB_DEFINES_SVH
`define MMB_DEFINES_SVH

// field positions inside a 3-bit cycle code {io_mem, direction, status}
`define MMB_FLD_IO_MEM 2
`define MMB_FLD_DIR 1
`define MMB_FLD_STATUS 0

// reset levels of the bus control outputs
`define MMB_RST_IO_MEM 1'b0
`define MMB_RST_DIR 1'b1
`define MMB_RST_STATUS 1'b1
`define MMB_RST_DEN_N 1'b1
`define MMB_RST_OE 1'b1

// timing: system clock rate and length of one half of a processor T-state
`define MMB_CLK_MHZ 250
`define MMB_HALF_STATE_NS 20
`define MMB_HALF_STATE_CYC ((`MMB_HALF_STATE_NS * `MMB_CLK_MHZ) / 1000)

`endif

// File: verilog/mmb_pkg.sv
/*
 * Types of the minimum-mode bus control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mmb_pkg;

  // cycle kinds coded as {io_mem, direction, status}
  typedef enum logic [2:0] {
    MMB_KIND_INT_ACK_STROBE_N = 3'h4,
    MMB_KIND_IO_RD = 3'h5,
    MMB_KIND_IO_WR = 3'h6,
    MMB_KIND_HALT = 3'h7,
    MMB_KIND_CODE = 3'h0,
    MMB_KIND_MEM_RD = 3'h1,
    MMB_KIND_MEM_WR = 3'h2,
    MMB_KIND_PASSIVE = 3'h3
  } mmb_kind_t;

  typedef enum logic [6:0] {
    MMB_ST_IDLE = 7'h01,
    MMB_ST_T1 = 7'h02,
    MMB_ST_T2 = 7'h04,
    MMB_ST_T3 = 7'h08,
    MMB_ST_TW = 7'h10,
    MMB_ST_T4 = 7'h20,
    MMB_ST_HOLD = 7'h40
  } mmb_state_t;

endpackage

// File: verilog/mmb_half_tick.sv
/*
 * Divider giving a one-cycle pulse at each half of a processor T-state.
 * Assumes one system clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module mmb_half_tick #(
  parameter int unsigned DIV = 5
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // enable pulse
  output logic tick_out
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= (cnt_q == LAST);
      if (cnt_q == LAST) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule

// File: verilog/mmb_bus_ctrl.sv
/*
 * Minimum-mode local bus control: T-state sequencer, transceiver enable
 * and direction, cycle status lines and the hold/acknowledge handshake.
 * Assumes: req_* come from logic on clk_sys_in; hold and ready are pins.
 * Floated pins are modelled as value 1 with output enable low; the
 * surrounding wire supplies the pull-up.
 */
// Summary of operation
// - transceiver enable low only in memory, I/O and int ack cycles
// - read and interrupt ack: enable from mid T2 until mid T4
// - write: enable from start of T2 until mid T4
// - during bus grant the transceiver enable floats at logic one
// - hold acknowledge rises mid-way through a T4 or idle state
// - bus control outputs float together with the acknowledge
// - hold request sampled low lowers the acknowledge
// - after release, drive resumes only when another cycle starts
// - status bit follows the timing of the low maximum-mode status bit
// - io high: 00 int ack, 01 io read, 10 io write, 11 halt
// - io low: 00 code, 01 mem read, 10 mem write, 11 passive
// - during bus grant the status bit floats at logic one
// - io/mem select valid from preceding T4 to the cycle's final T4
// - direction high transmit, same timing as select, floats during grant
`timescale 1ns/1ps
`include "mmb_defines.svh"
module mmb_bus_ctrl
  import mmb_pkg::*;
#(
  parameter int unsigned HALF_STATE_CYC = `MMB_HALF_STATE_CYC
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // cycle requests from the execution side
  input wire logic req_valid_in,
  input wire mmb_kind_t req_kind_in,
  output logic req_taken_out,
  output logic cycle_done_out,
  // pins from the bus
  input wire logic hold_request_in,
  input wire logic ready_in,
  // hold acknowledge
  output logic bus_grant_ack_out,
  // bus control pins, value and output enable
  output logic xcvr_output_enable_n_out,
  output logic xcvr_output_enable_n_oe_out,
  output logic xcvr_direction_out,
  output logic xcvr_direction_oe_out,
  output logic cycle_status_bit_out,
  output logic cycle_status_bit_oe_out,
  output logic io_mem_sel_out,
  output logic io_mem_sel_oe_out
);

  function automatic logic is_write(input mmb_kind_t k);
    return k == MMB_KIND_IO_WR || k == MMB_KIND_MEM_WR;
  endfunction

  function automatic logic has_xfer(input mmb_kind_t k);
    return k != MMB_KIND_HALT && k != MMB_KIND_PASSIVE;
  endfunction

  logic tick;
  logic half_q;
  mmb_state_t state_q;
  mmb_kind_t kind_q;
  logic next_q;
  logic hold_meta_q;
  logic hold_s_q;
  logic rdy_meta_q;
  logic rdy_s_q;
  logic mid;
  logic bnd;
  logic at_edge;
  logic grant_pt;
  logic load_pt;
  logic release_pt;
  logic idle_pt;

  mmb_half_tick #(
    .DIV(HALF_STATE_CYC)
  ) u_tick (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .tick_out(tick)
  );

  // pins cross in through two flops
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hold_meta_q <= 1'b0;
      hold_s_q <= 1'b0;
      rdy_meta_q <= 1'b0;
      rdy_s_q <= 1'b0;
    end else begin
      hold_meta_q <= hold_request_in;
      hold_s_q <= hold_meta_q;
      rdy_meta_q <= ready_in;
      rdy_s_q <= rdy_meta_q;
    end
  end

  // mid: start of a state's second half; bnd: end of the state
  assign mid = tick & ~half_q;
  assign bnd = tick & half_q;
  // idle counts as T4 for the grant; never decided inside T2 or T3
  assign at_edge = mid & (state_q == MMB_ST_T4 || state_q == MMB_ST_IDLE);
  assign grant_pt = at_edge & hold_s_q;
  // hold wins over a waiting request
  assign load_pt = at_edge & ~hold_s_q & req_valid_in;
  assign idle_pt = mid & (state_q == MMB_ST_T4) & ~hold_s_q & ~req_valid_in;
  assign release_pt = bnd & (state_q == MMB_ST_HOLD) & ~hold_s_q;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      half_q <= 1'b0;
    end else if (tick) begin
      half_q <= ~half_q;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      next_q <= 1'b0;
    end else if (load_pt) begin
      next_q <= 1'b1;
    end else if (bnd && state_q != MMB_ST_HOLD) begin
      next_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      kind_q <= MMB_KIND_PASSIVE;
    end else if (load_pt) begin
      kind_q <= req_kind_in;
    end
  end

  // T-state sequencer
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= MMB_ST_IDLE;
    end else if (grant_pt) begin
      state_q <= MMB_ST_HOLD;
    end else if (bnd) begin
      case (state_q)
        MMB_ST_IDLE: begin
          state_q <= next_q ? MMB_ST_T1 : MMB_ST_IDLE;
        end
        MMB_ST_T1: begin
          state_q <= MMB_ST_T2;
        end
        MMB_ST_T2: begin
          state_q <= MMB_ST_T3;
        end
        MMB_ST_T3, MMB_ST_TW: begin
          state_q <= rdy_s_q ? MMB_ST_T4 : MMB_ST_TW;
        end
        MMB_ST_T4: begin
          state_q <= next_q ? MMB_ST_T1 : MMB_ST_IDLE;
        end
        MMB_ST_HOLD: begin
          // stay floated until the next cycle loads
          state_q <= hold_s_q ? MMB_ST_HOLD : MMB_ST_IDLE;
        end
        default: begin
          state_q <= MMB_ST_IDLE;
        end
      endcase
    end
  end

  // hold acknowledge handshake
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bus_grant_ack_out <= 1'b0;
    end else if (grant_pt) begin
      bus_grant_ack_out <= 1'b1;
    end else if (release_pt) begin
      bus_grant_ack_out <= 1'b0;
    end
  end

  // status lines change in the T4 (or idle) ahead of the cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      io_mem_sel_out <= `MMB_RST_IO_MEM;
      xcvr_direction_out <= `MMB_RST_DIR;
      cycle_status_bit_out <= `MMB_RST_STATUS;
      io_mem_sel_oe_out <= `MMB_RST_OE;
      xcvr_direction_oe_out <= `MMB_RST_OE;
      cycle_status_bit_oe_out <= `MMB_RST_OE;
    end else if (grant_pt) begin
      // float at logic one; pull-ups read the halt code
      io_mem_sel_out <= 1'b1;
      xcvr_direction_out <= 1'b1;
      cycle_status_bit_out <= 1'b1;
      io_mem_sel_oe_out <= 1'b0;
      xcvr_direction_oe_out <= 1'b0;
      cycle_status_bit_oe_out <= 1'b0;
    end else if (load_pt) begin
      io_mem_sel_out <= req_kind_in[`MMB_FLD_IO_MEM];
      xcvr_direction_out <= req_kind_in[`MMB_FLD_DIR];
      cycle_status_bit_out <= req_kind_in[`MMB_FLD_STATUS];
      io_mem_sel_oe_out <= 1'b1;
      xcvr_direction_oe_out <= 1'b1;
      cycle_status_bit_oe_out <= 1'b1;
    end else if (idle_pt) begin
      // no follow-on cycle: direction and status high (passive, or halt if io), select keeps its level
      xcvr_direction_out <= 1'b1;
      cycle_status_bit_out <= 1'b1;
    end
  end

  // transceiver enable
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      xcvr_output_enable_n_out <= `MMB_RST_DEN_N;
      xcvr_output_enable_n_oe_out <= `MMB_RST_OE;
    end else if (grant_pt) begin
      xcvr_output_enable_n_out <= 1'b1;
      xcvr_output_enable_n_oe_out <= 1'b0;
    end else begin
      if (load_pt) begin
        xcvr_output_enable_n_oe_out <= 1'b1;
      end
      if (mid && state_q == MMB_ST_T4) begin
        xcvr_output_enable_n_out <= 1'b1;
      end else if (bnd && state_q == MMB_ST_T1 &&
                   has_xfer(kind_q) && is_write(kind_q)) begin
        xcvr_output_enable_n_out <= 1'b0;
      end else if (mid && state_q == MMB_ST_T2 &&
                   has_xfer(kind_q) && !is_write(kind_q)) begin
        xcvr_output_enable_n_out <= 1'b0;
      end
    end
  end

  // user-side strobes
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      req_taken_out <= 1'b0;
      cycle_done_out <= 1'b0;
    end else begin
      req_taken_out <= load_pt;
      // a grant in mid T4 still ends the cycle for the user side
      cycle_done_out <= (bnd || grant_pt) && state_q == MMB_ST_T4;
    end
  end

endmodule

// File: testbench/mmb_bus_ctrl_sva.sv
/* checker: timing relations of the bus control outputs.
   assumes the bind below and HALF_STATE_CYC of at least 2. */
`timescale 1ns/1ps
module mmb_bus_ctrl_sva
  import mmb_pkg::*;
#(
  parameter int unsigned HALF_STATE_CYC = 5
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire mmb_kind_t req_kind_in,
  input wire logic req_taken_out,
  input wire logic hold_request_in,
  input wire logic bus_grant_ack_out,
  input wire logic xcvr_output_enable_n_out,
  input wire logic xcvr_output_enable_n_oe_out,
  input wire logic xcvr_direction_out,
  input wire logic xcvr_direction_oe_out,
  input wire logic cycle_status_bit_oe_out,
  input wire logic cycle_status_bit_out,
  input wire logic io_mem_sel_out,
  input wire logic io_mem_sel_oe_out
);
  // taken pulse to enable edge: mid T2 for reads, T2 start for writes
  localparam int RD_DLY = 4 * HALF_STATE_CYC - 1;
  localparam int WR_DLY = 3 * HALF_STATE_CYC - 1;
  // two sync flops plus up to one full state to the next end-of-state tick
  localparam int ACK_MAX = 2 * HALF_STATE_CYC + 2;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_den_cycle;
    !xcvr_output_enable_n_out |->
      !(xcvr_direction_out && cycle_status_bit_out);
  endproperty
  a_den_cycle: assert property (p_den_cycle)
    else $error("enable low outside a data cycle");
  property p_rd_den;
    req_taken_out && !xcvr_direction_out |->
      ##RD_DLY xcvr_output_enable_n_out ##1 !xcvr_output_enable_n_out;
  endproperty
  a_rd_den: assert property (p_rd_den)
    else $error("read enable edge misplaced");
  property p_wr_den;
    req_taken_out && xcvr_direction_out && !cycle_status_bit_out |->
      ##WR_DLY xcvr_output_enable_n_out ##1 !xcvr_output_enable_n_out;
  endproperty
  a_wr_den: assert property (p_wr_den)
    else $error("write enable edge misplaced");
  property p_grant_float;
    bus_grant_ack_out |-> !(xcvr_output_enable_n_oe_out ||
      xcvr_direction_oe_out || cycle_status_bit_oe_out || io_mem_sel_oe_out);
  endproperty
  a_grant_float: assert property (p_grant_float)
    else $error("pin driven during grant");
  property p_ack_fall;
    $fell(hold_request_in) && bus_grant_ack_out |->
      ##[1:ACK_MAX] !bus_grant_ack_out;
  endproperty
  a_ack_fall: assert property (p_ack_fall)
    else $error("grant not withdrawn");
  property p_code;
    req_taken_out |-> {io_mem_sel_out, xcvr_direction_out,
      cycle_status_bit_out} == $past(req_kind_in);
  endproperty
  a_code: assert property (p_code)
    else $error("cycle code differs from request");
  property p_no_take;
    bus_grant_ack_out |-> !req_taken_out;
  endproperty
  a_no_take: assert property (p_no_take)
    else $error("cycle taken during grant");
  property p_resume;
    $rose(xcvr_direction_oe_out) |-> req_taken_out;
  endproperty
  a_resume: assert property (p_resume)
    else $error("drive resumed without a cycle");
endmodule

bind mmb_bus_ctrl mmb_bus_ctrl_sva #(.HALF_STATE_CYC(HALF_STATE_CYC))
  u_mmb_bus_ctrl_sva (.clk_sys_in, .rst_in, .req_kind_in, .req_taken_out,
  .hold_request_in, .bus_grant_ack_out, .xcvr_output_enable_n_out,
  .xcvr_output_enable_n_oe_out, .xcvr_direction_out, .xcvr_direction_oe_out,
  .cycle_status_bit_oe_out, .cycle_status_bit_out, .io_mem_sel_out,
  .io_mem_sel_oe_out);

// File: testbench/mmb_other_master.sv
/* model of the other bus master and the ready source.
   assumes the bench sets want_in and stall_in on the clock. */
`timescale 1ns/1ps
module mmb_other_master (
  input wire logic clk_sys_in,
  input wire logic want_in,
  input wire logic stall_in,
  output logic hold_out,
  output logic ready_out
);
  initial begin
    hold_out = 1'b0;
    ready_out = 1'b1;
  end
  // registered on the same clock so set-up is always met
  always @(posedge clk_sys_in) begin
    hold_out <= want_in;
    ready_out <= !stall_in;
  end
endmodule

// File: testbench/mmb_bus_ctrl_tb.sv
/* self-checking bench of the bus control block.
   assumes the checker bind and the other-master model. */
`timescale 1ns/1ps
module mmb_bus_ctrl_tb
  import mmb_pkg::*;
;
  localparam int HC = 2;
  logic clk_sys_in, rst_in, req_valid_in, req_taken_out, cycle_done_out;
  mmb_kind_t req_kind_in;
  logic hold_request_in, ready_in, bus_grant_ack_out, want, stall;
  logic xcvr_output_enable_n_out, xcvr_output_enable_n_oe_out;
  logic xcvr_direction_out, xcvr_direction_oe_out;
  logic cycle_status_bit_out, cycle_status_bit_oe_out;
  logic io_mem_sel_out, io_mem_sel_oe_out;
  int errors = 0;
  int samples_checked = 0;
  // pull-ups on the floated pins
  wire den_w = xcvr_output_enable_n_oe_out ? xcvr_output_enable_n_out : 1'b1;
  wire dir_w = xcvr_direction_oe_out ? xcvr_direction_out : 1'b1;
  wire st_w = cycle_status_bit_oe_out ? cycle_status_bit_out : 1'b1;
  wire io_w = io_mem_sel_oe_out ? io_mem_sel_out : 1'b1;
  mmb_bus_ctrl #(.HALF_STATE_CYC(HC)) u_mmb_bus_ctrl (.clk_sys_in, .rst_in,
    .req_valid_in, .req_kind_in, .req_taken_out, .cycle_done_out,
    .hold_request_in, .ready_in, .bus_grant_ack_out, .xcvr_output_enable_n_out,
    .xcvr_output_enable_n_oe_out, .xcvr_direction_out, .xcvr_direction_oe_out,
    .cycle_status_bit_out, .cycle_status_bit_oe_out, .io_mem_sel_out,
    .io_mem_sel_oe_out);
  mmb_other_master u_mmb_other_master (.clk_sys_in, .want_in(want),
    .stall_in(stall), .hold_out(hold_request_in), .ready_out(ready_in));
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic flag(input int s);
    case (s)
      0: return req_taken_out;
      1: return cycle_done_out;
      2: return bus_grant_ack_out;
      default: return !bus_grant_ack_out;
    endcase
  endfunction
  task automatic wait_hi(input int s);
    int n;
    n = 0;
    while (n < 400 && flag(s) !== 1'b1) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(8'(n < 400), 8'h01);
  endtask
  // one cycle; enable low time counted, slow adds wait states
  task automatic sc_cycle(input mmb_kind_t k, input logic slow);
    int lo, i, exp;
    lo = 0;
    i = 0;
    exp = k[1] ? (k[0] ? 0 : 5 * HC) : 4 * HC;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_kind_in <= k;
    stall <= slow;
    wait_hi(0);
    chk({5'h00, io_mem_sel_out, xcvr_direction_out, cycle_status_bit_out},
      8'(k));
    while (cycle_done_out !== 1'b1 && i < 200) begin
      @(posedge clk_sys_in);
      if (i == 0) req_valid_in <= 1'b0;
      if (i == 12) stall <= 1'b0;
      @(negedge clk_sys_in);
      lo += (xcvr_output_enable_n_out === 1'b0);
      i++;
    end
    chk(slow ? 8'(lo > exp) : 8'(lo),
      slow ? 8'h01 : 8'(exp));
  endtask
  // back-to-back: next request taken at T4 mid, T1 follows at once
  task automatic sc_back;
    time t0;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_kind_in <= MMB_KIND_CODE;
    wait_hi(0);
    t0 = $time;
    @(posedge clk_sys_in);
    req_kind_in <= MMB_KIND_MEM_WR;
    @(negedge clk_sys_in);
    wait_hi(0);
    chk(8'(($time - t0) / 4), 8'(8 * HC));
    chk({5'h00, io_mem_sel_out, xcvr_direction_out, cycle_status_bit_out},
      8'(MMB_KIND_MEM_WR));
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    wait_hi(1);
    @(negedge clk_sys_in);
    wait_hi(1);
  endtask
  // reset pulled mid-way through a write cycle, enable already low
  task automatic sc_reset;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_kind_in <= MMB_KIND_MEM_WR;
    wait_hi(0);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    repeat (4 * HC) @(posedge clk_sys_in);
    rst_in <= 1'b1;
    @(negedge clk_sys_in);
    chk({3'h0, bus_grant_ack_out, xcvr_output_enable_n_out,
      xcvr_direction_out, cycle_status_bit_out, io_mem_sel_out},
      8'h0e);
    chk({2'h0, req_taken_out, cycle_done_out, xcvr_output_enable_n_oe_out,
      xcvr_direction_oe_out, cycle_status_bit_oe_out, io_mem_sel_oe_out},
      8'h0f);
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
  endtask
  // hold raised mid-cycle is granted only at T4 mid
  task automatic sc_hold_mid;
    int n;
    n = 0;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_kind_in <= MMB_KIND_MEM_RD;
    wait_hi(0);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    want <= 1'b1;
    while (bus_grant_ack_out !== 1'b1 && n < 200) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(8'(n), 8'(8 * HC));
    chk(8'(cycle_done_out), 8'h01);
    @(posedge clk_sys_in);
    want <= 1'b0;
    wait_hi(3);
  endtask
  task automatic sc_hold;
    int n;
    n = 0;
    @(posedge clk_sys_in);
    want <= 1'b1;
    wait_hi(2);
    chk({den_w, dir_w, st_w, io_w}, 8'h0f);
    chk({xcvr_output_enable_n_oe_out, xcvr_direction_oe_out,
      cycle_status_bit_oe_out, io_mem_sel_oe_out}, 8'h00);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_kind_in <= MMB_KIND_IO_WR;
    repeat (20) begin
      @(negedge clk_sys_in);
      n += req_taken_out;
    end
    chk(8'(n), 8'h00);
    @(posedge clk_sys_in);
    want <= 1'b0;
    wait_hi(3);
    chk(xcvr_direction_oe_out, 1'b0);
    wait_hi(0);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    wait_hi(1);
  endtask
  initial begin
    #20000;
    errors++;
    results();
  end
  initial begin
    rst_in = 1'b1;
    req_valid_in = 1'b0;
    req_kind_in = MMB_KIND_CODE;
    want = 1'b0;
    stall = 1'b0;
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (k != 3) sc_cycle(mmb_kind_t'(k), 1'b0);
    end
    sc_cycle(MMB_KIND_IO_RD, 1'b1);
    sc_hold_mid();
    sc_hold();
    sc_back();
    sc_reset();
    sc_cycle(MMB_KIND_MEM_RD, 1'b0);
    results();
  end
endmodule
